// >>> hw/alrb_pkg.sv
// Constants, types and register map of the audio link register bank.
// Assumes a 10 MHz core clock and a link bit clock far slower than it.
package alrb_pkg;
    // Register byte addresses on the link
    localparam logic [6:0] A_RESET = 7'h00;
    localparam logic [6:0] A_PWRDN = 7'h26;
    localparam logic [6:0] A_EXTID = 7'h28;
    localparam logic [6:0] A_EXTSC = 7'h2a;
    localparam logic [6:0] A_RATE_F = 7'h2c;
    localparam logic [6:0] A_RATE_S = 7'h2e;
    localparam logic [6:0] A_RATE_L = 7'h30;
    localparam logic [6:0] A_ADC_A = 7'h32;
    localparam logic [6:0] A_ADC_B = 7'h34;
    localparam logic [6:0] A_EXT_LAST = 7'h3a;
    localparam logic [6:0] A_MODID = 7'h3c;
    localparam logic [6:0] A_CFG = 7'h5a;
    localparam logic [6:0] A_VEND1 = 7'h7c;
    localparam logic [6:0] A_VEND2 = 7'h7e;
    // Field positions and fixed values
    localparam int SHUTDOWN_BIT = 12;
    localparam int SEL_BIT = 14;
    localparam int FC_BIT = 0;
    localparam logic [15:0] RATE_48K = 16'hbb80;
    localparam logic [15:0] RATE_44K = 16'hac44;
    localparam logic [3:0] PWRDN_LOW = 4'he;
    localparam logic [3:0] EXTSC_MID = 4'h7;
    // Shadow reset values
    localparam logic RST_SHUTDOWN = 1'b0;
    localparam logic RST_FC = 1'b1;
    localparam logic RST_RATE44 = 1'b0;
    // Link frame: tag plus two 20-bit slots
    localparam int FRAME_BITS = 56;
    localparam logic [7:0] FRAME_LAST = 8'd56;
    // Warm reset: sync held high with the bit clock still
    localparam int CLK_MHZ = 10;
    localparam int WARM_MIN_NS = 1000;
    localparam int WARM_CYC = (WARM_MIN_NS * CLK_MHZ + 999) / 1000;
    // Reserved-bit masks for the standard and extended audio space
    localparam logic [15:0] RSV_MASK [0:29] = '{default: 16'hffff};

    typedef struct packed {
        logic bclk_s1, bclk_s2, bclk_d;
        logic sync_s1, sync_s2, sync_f, sync_r;
        logic sdo_s1, sdo_s2;
        logic sel_s1, sel_s2;
        logic [7:0] bit_cnt;
        logic [55:0] in_sr;
        logic [55:0] out_sr;
        logic [55:0] resp;
        logic resp_pend;
        logic [4:0] warm_cnt;
        logic shutdown, fc_mode, rate44, rst_req, sdi;
        logic [15:0] dsp_rdata;
        logic [63:0][15:0] ram;
    } alrb_state_t;
endpackage

// >>> hw/alrb_reg_bank.sv
// Register bank reached over the serial audio link, with a DSP port.
// Assumes link pins are asynchronous to clk_in; the bit clock is sampled.
`timescale 1ns/10ps

// Overview of operation
// - Reads return backing RAM word by default
// - Extended and modem ID registers: bit14 select pin, bit15 zero
// - DSP never sees the select pin
// - Shutdown bit forces clock and data low
// - Warm reset clears the shutdown bit
// - Shutdown bit reads live flop, not RAM
// - Rate registers read 48k or 44.1k code
// - Full compliance applies RSV_MASK, all ones, clearing no bits
// - Without compliance, full word returned
// - Odd read: tags set, echo address, zeros
// - Writes store full word normally
// - Shadow flops follow register writes
// - Reset or write 00h restores shadows
// - DSP rewrites RAM defaults after reset
// - Vendor ID writes are ignored
// - Extended_audio_identity write ignored
// - Powerdown write forces low bits 1110
// - Ext status write forces bits 9:6 0111
// - ADC rate writes store 48k code
// - Link and DSP accesses are arbitrated
module alrb_reg_bank
    import alrb_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link pins
    input wire logic bit_clk_in,
    input wire logic sync_in,
    input wire logic sdata_out_in,
    output logic sdata_in_out,
    output logic sdata_in_oe_out,
    output logic bit_clk_force_low_out,
    // Strap
    input wire logic codec_select_pin_in,
    // DSP port
    input wire logic dsp_req_in,
    input wire logic dsp_we_in,
    input wire logic [5:0] dsp_idx_in,
    input wire logic [15:0] dsp_wdata_in,
    output logic dsp_ready_out,
    output logic [15:0] dsp_rdata_out,
    output logic reset_request_out,
    output logic full_compliance_select_out
);

    function automatic logic is_rate(input logic [6:0] a);
        return a == A_RATE_F || a == A_RATE_S || a == A_RATE_L;
    endfunction

    alrb_state_t st_r, st_nxt;

    logic fall_edge, rise_edge, frame_done;
    logic [15:0] tag;
    logic [19:0] slot1, slot2;
    logic [6:0] laddr;
    logic [5:0] lidx;
    logic [15:0] wd, rd;
    logic lwr_en, lrd_en, link_busy;

    always_comb begin
        fall_edge = !st_r.bclk_s2 && st_r.bclk_d;
        rise_edge = st_r.bclk_s2 && !st_r.bclk_d;
        frame_done = fall_edge && st_r.bit_cnt == FRAME_LAST - 8'd1;
        tag = st_r.in_sr[54:39];
        slot1 = st_r.in_sr[38:19];
        slot2 = {st_r.in_sr[18:0], st_r.sdo_s2};
        laddr = slot1[18:12];
        lidx = laddr[6:1];
        wd = slot2[19:4];
        lwr_en = frame_done && tag[15] && tag[14] && tag[13] && !slot1[19];
        lrd_en = frame_done && tag[15] && tag[14] && slot1[19];
        // Link is served first; the DSP waits a cycle
        link_busy = lwr_en || lrd_en;
        // Read path
        rd = st_r.ram[lidx];
        if (st_r.fc_mode && laddr <= A_EXT_LAST) begin
            rd = rd & RSV_MASK[lidx[4:0]];
        end
        if (laddr == A_EXTID || laddr == A_MODID) begin
            rd[15] = 1'b0;
            rd[SEL_BIT] = st_r.sel_s2;
        end
        if (laddr == A_PWRDN) begin
            rd[SHUTDOWN_BIT] = st_r.shutdown;
        end
        if (is_rate(laddr)) begin
            rd = st_r.rate44 ? RATE_44K : RATE_48K;
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.bclk_s1 = bit_clk_in;
        st_nxt.bclk_s2 = st_r.bclk_s1;
        st_nxt.bclk_d = st_r.bclk_s2;
        st_nxt.sync_s1 = sync_in;
        st_nxt.sync_s2 = st_r.sync_s1;
        st_nxt.sdo_s1 = sdata_out_in;
        st_nxt.sdo_s2 = st_r.sdo_s1;
        st_nxt.sel_s1 = codec_select_pin_in;
        st_nxt.sel_s2 = st_r.sel_s1;
        st_nxt.rst_req = 1'b0;
        // Controller drives on rising edge, we sample on falling
        if (fall_edge) begin
            st_nxt.sync_f = st_r.sync_s2;
            st_nxt.in_sr = {st_r.in_sr[54:0], st_r.sdo_s2};
            if (st_r.sync_s2 && !st_r.sync_f) begin
                st_nxt.bit_cnt = 8'd1;
            end else if (st_r.bit_cnt != 8'd0 && st_r.bit_cnt < FRAME_LAST) begin
                st_nxt.bit_cnt = st_r.bit_cnt + 8'd1;
            end
        end
        // Response goes out in the frame after the request
        if (rise_edge) begin
            st_nxt.sync_r = st_r.sync_s2;
            if (st_r.sync_s2 && !st_r.sync_r) begin
                st_nxt.out_sr = st_r.resp_pend ? st_r.resp : {1'b1, 55'h0};
                st_nxt.resp_pend = 1'b0;
            end else begin
                st_nxt.out_sr = {st_r.out_sr[54:0], 1'b0};
            end
            st_nxt.sdi = st_nxt.out_sr[FRAME_BITS-1] && !st_r.shutdown;
        end
        if (st_r.shutdown) begin
            st_nxt.sdi = 1'b0;
        end
        // Warm reset: sync high and no bit clock edges
        if (st_r.sync_s2 && !rise_edge && !fall_edge) begin
            if (st_r.warm_cnt == 5'(WARM_CYC)) begin
                st_nxt.shutdown = RST_SHUTDOWN;
            end else begin
                st_nxt.warm_cnt = st_r.warm_cnt + 5'd1;
            end
        end else begin
            st_nxt.warm_cnt = 5'd0;
        end
        if (lrd_en) begin
            st_nxt.resp_pend = 1'b1;
            if (laddr[0]) begin
                st_nxt.resp = {3'b111, 13'h0, 1'b0, laddr, 12'h0, 20'h0};
            end else begin
                st_nxt.resp = {3'b111, 13'h0, 1'b0, laddr, 12'h0, rd, 4'h0};
            end
        end
        if (lwr_en && !laddr[0]) begin
            case (laddr)
                A_VEND1, A_VEND2: begin
                    st_nxt.ram[lidx] = st_r.ram[lidx];
                end
                A_EXTID: begin
                    st_nxt.ram[lidx] = st_r.ram[lidx];
                end
                A_PWRDN: begin
                    st_nxt.ram[lidx] = {wd[15:4], PWRDN_LOW};
                    st_nxt.shutdown = wd[SHUTDOWN_BIT];
                end
                A_EXTSC: begin
                    st_nxt.ram[lidx] = {wd[15:10], EXTSC_MID, wd[5:0]};
                end
                A_ADC_A, A_ADC_B: begin
                    st_nxt.ram[lidx] = RATE_48K;
                end
                A_RATE_F, A_RATE_S, A_RATE_L: begin
                    st_nxt.ram[lidx] = wd;
                    st_nxt.rate44 = wd == RATE_44K;
                end
                A_CFG: begin
                    st_nxt.ram[lidx] = wd;
                    st_nxt.fc_mode = wd[FC_BIT];
                end
                A_RESET: begin
                    st_nxt.ram[lidx] = wd;
                    st_nxt.shutdown = RST_SHUTDOWN;
                    st_nxt.fc_mode = RST_FC;
                    st_nxt.rate44 = RST_RATE44;
                    st_nxt.rst_req = 1'b1;
                end
                default: begin
                    st_nxt.ram[lidx] = wd;
                end
            endcase
        end
        // DSP sees raw RAM only; no select pin path
        if (dsp_req_in && !link_busy) begin
            if (dsp_we_in) begin
                st_nxt.ram[dsp_idx_in] = dsp_wdata_in;
            end
            st_nxt.dsp_rdata = st_r.ram[dsp_idx_in];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '0;
            st_r.fc_mode <= RST_FC;
            st_r.shutdown <= RST_SHUTDOWN;
            st_r.rate44 <= RST_RATE44;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sdata_in_out = st_r.sdi;
    assign sdata_in_oe_out = 1'b1;
    assign bit_clk_force_low_out = st_r.shutdown;
    assign dsp_ready_out = !link_busy;
    assign dsp_rdata_out = st_r.dsp_rdata;
    assign reset_request_out = st_r.rst_req;
    assign full_compliance_select_out = st_r.fc_mode;

    sequence s_wr(logic [6:0] a);
        lwr_en && laddr == a;
    endsequence

    sequence s_rd_odd;
        lrd_en && laddr[0];
    endsequence

    // Frame start as seen on the rising bit clock edge
    sequence s_frame_start;
        rise_edge && st_r.sync_s2 && !st_r.sync_r;
    endsequence

    // Data is forced low one cycle late, so only a settled shutdown is checked
    shutdown_quiet_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (st_r.shutdown && $past(st_r.shutdown)) |-> !sdata_in_out && bit_clk_force_low_out)
        else $error("data line not held low in shutdown");

    warm_clear_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (st_r.sync_s2 && !rise_edge && !fall_edge
            && st_r.warm_cnt == 5'(WARM_CYC)) |=> !st_r.shutdown)
        else $error("warm reset did not clear shutdown");

    rate_flag_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (lwr_en && is_rate(laddr)) |=> st_r.rate44 == ($past(wd) == RATE_44K))
        else $error("rate flag wrong after write");

    adc_fixed_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_wr(A_ADC_A) |=> st_r.ram[A_ADC_A[6:1]] == RATE_48K)
        else $error("adc rate not fixed");

    vendor_keep_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (s_wr(A_VEND1) && !dsp_req_in) |=> $stable(st_r.ram[A_VEND1[6:1]]))
        else $error("vendor register changed");

    soft_reset_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_wr(A_RESET) |=> st_r.fc_mode && !st_r.shutdown && reset_request_out
            ##1 !reset_request_out)
        else $error("soft reset did not restore shadows");

    pwrdn_low_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_wr(A_PWRDN) |=> st_r.ram[A_PWRDN[6:1]][3:0] == PWRDN_LOW
            && st_r.shutdown == $past(wd[SHUTDOWN_BIT]))
        else $error("powerdown write wrong");

    extsc_mid_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_wr(A_EXTSC) |=> st_r.ram[A_EXTSC[6:1]][9:6] == EXTSC_MID)
        else $error("ext status write wrong");

    odd_read_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_rd_odd |=> st_r.resp_pend && st_r.resp[55:53] == 3'b111
            && st_r.resp[19:0] == 20'h0)
        else $error("odd read reply wrong");

    id_select_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (lrd_en && laddr == A_EXTID) |=> st_r.resp[19] == 1'b0
            && st_r.resp[18] == $past(st_r.sel_s2))
        else $error("id read select bits wrong");

    modid_select_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (lrd_en && laddr == A_MODID) |=> st_r.resp[19] == 1'b0
            && st_r.resp[18] == $past(st_r.sel_s2))
        else $error("modem id read select bits wrong");

    rate_read_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (lrd_en && is_rate(laddr)) |=> st_r.resp[19:4]
            == ($past(st_r.rate44) ? RATE_44K : RATE_48K))
        else $error("rate register read wrong");

    shutdown_read_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (lrd_en && laddr == A_PWRDN) |=> st_r.resp[4 + SHUTDOWN_BIT]
            == $past(st_r.shutdown))
        else $error("shutdown bit read not live");

    plain_read_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (lrd_en && !laddr[0] && laddr > A_EXT_LAST && laddr != A_MODID)
            |=> st_r.resp[19:4] == $past(st_r.ram[lidx]))
        else $error("plain read not from RAM");

    odd_echo_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_rd_odd |=> st_r.resp[38:32] == $past(laddr))
        else $error("odd read address not echoed");

    reply_load_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (s_frame_start and st_r.resp_pend) |=> st_r.out_sr == $past(st_r.resp)
            && !st_r.resp_pend)
        else $error("pending reply not sent");

    cfg_write_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_wr(A_CFG) |=> st_r.ram[A_CFG[6:1]] == $past(wd)
            && st_r.fc_mode == $past(wd[FC_BIT]))
        else $error("config write not stored");

    extid_keep_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (s_wr(A_EXTID) && !dsp_req_in) |=> $stable(st_r.ram[A_EXTID[6:1]]))
        else $error("extended id register changed");

    vendor2_keep_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (s_wr(A_VEND2) && !dsp_req_in) |=> $stable(st_r.ram[A_VEND2[6:1]]))
        else $error("second vendor register changed");

    adc_b_fixed_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_wr(A_ADC_B) |=> st_r.ram[A_ADC_B[6:1]] == RATE_48K)
        else $error("second adc rate not fixed");

    pwrdn_upper_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_wr(A_PWRDN) |=> st_r.ram[A_PWRDN[6:1]][15:4] == $past(wd[15:4]))
        else $error("powerdown upper bits not stored");

    extsc_outer_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_wr(A_EXTSC) |=> st_r.ram[A_EXTSC[6:1]][15:10] == $past(wd[15:10])
            && st_r.ram[A_EXTSC[6:1]][5:0] == $past(wd[5:0]))
        else $error("ext status outer bits not stored");

    reset_pulse_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        reset_request_out |=> !reset_request_out)
        else $error("reset request longer than one cycle");

    dsp_write_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (dsp_req_in && dsp_we_in && !link_busy)
            |=> st_r.ram[$past(dsp_idx_in)] == $past(dsp_wdata_in))
        else $error("dsp write not stored");

    dsp_read_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (dsp_req_in && !link_busy) |=> dsp_rdata_out == $past(st_r.ram[dsp_idx_in]))
        else $error("dsp read not raw RAM");

    link_wins_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (dsp_req_in && link_busy) |=> $stable(dsp_rdata_out))
        else $error("dsp served during link access");

    warm_bound_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        st_r.warm_cnt <= 5'(WARM_CYC))
        else $error("warm reset counter overran");

endmodule

// >>> verification/alrb_link_ctrl.sv
// Behavioural link controller: sends frames, warm reset, captures replies.
// Assumes a 100 ns clk_in; bit clock is 4 cycles high, 4 low (800 ns).
`timescale 1ns/10ps
module alrb_link_ctrl (
    // Clock
    input wire logic clk_in,
    // Link pins
    input wire logic sdata_in_in,
    output logic bit_clk_out,
    output logic sync_out,
    output logic sdata_out,
    // Captured reply
    output logic [55:0] rx_out,
    output logic rx_done_out
);
    initial begin
        bit_clk_out = 1'b0;
        sync_out = 1'b0;
        sdata_out = 1'b0;
        rx_out = '0;
        rx_done_out = 1'b0;
    end
    // Clock stands still between frames; data shows its inverse once released
    task automatic frame(input logic [55:0] tx);
        for (int i = 55; i >= 0; i--) begin
            @(posedge clk_in);
            bit_clk_out <= 1'b1;
            sync_out <= (i >= 40);
            sdata_out <= tx[i];
            repeat (4) @(posedge clk_in);
            bit_clk_out <= 1'b0;
            repeat (3) @(posedge clk_in);
            rx_out[i] <= sdata_in_in;
        end
        @(posedge clk_in);
        sdata_out <= ~sdata_out;
        rx_done_out <= 1'b1;
        @(posedge clk_in);
        rx_done_out <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask
    // Sync held high with no bit clock edge
    task automatic warm();
        @(posedge clk_in);
        sync_out <= 1'b1;
        repeat (20) @(posedge clk_in);
        sync_out <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask
endmodule

// >>> verification/alrb_reg_bank_tb.sv
// Self-checking bench for the audio link register bank.
// Assumes the link controller model alrb_link_ctrl drives the link pins.
`timescale 1ns/10ps
module alrb_reg_bank_tb import alrb_pkg::*; ;
    logic clk_in = 1'b0, rst_in = 1'b1, sel = 1'b1;
    logic dsp_req = 1'b0, dsp_we = 1'b0, dchk = 1'b0;
    logic [5:0] dsp_idx = '0;
    logic [15:0] dsp_wd = '0, r, r0, dsp_rd;
    logic sdi, bfl, rrq, fc, bclk, sync, sdo, rxd, oe, rdy;
    logic [55:0] rx;
    logic [31:0] seed = 32'h1cd7692f;
    logic [23:0] lq[$];
    logic [15:0] dq[$];
    int num_errors = 0, tests_run = 0, rpc = 0;

    always #50 clk_in = ~clk_in;

    alrb_reg_bank i_alrb_reg_bank (.clk_in(clk_in), .rst_in(rst_in), .bit_clk_in(bclk),
        .sync_in(sync), .sdata_out_in(sdo), .sdata_in_out(sdi), .sdata_in_oe_out(oe),
        .bit_clk_force_low_out(bfl), .codec_select_pin_in(sel), .dsp_req_in(dsp_req),
        .dsp_we_in(dsp_we), .dsp_idx_in(dsp_idx), .dsp_wdata_in(dsp_wd), .dsp_ready_out(rdy),
        .dsp_rdata_out(dsp_rd), .reset_request_out(rrq), .full_compliance_select_out(fc));
    alrb_link_ctrl i_alrb_link_ctrl (.clk_in(clk_in), .sdata_in_in(sdi), .bit_clk_out(bclk),
        .sync_out(sync), .sdata_out(sdo), .rx_out(rx), .rx_done_out(rxd));

    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic chk(input string n, input logic [55:0] got, input logic [55:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic lw(input logic [6:0] a, input logic [15:0] d);
        i_alrb_link_ctrl.frame({16'he000, 1'b0, a, 12'h0, d, 4'h0});
    endtask
    // Reply comes in the frame after the request
    task automatic lr(input logic [6:0] a, input logic [15:0] e);
        lq.push_back({1'b1, a, e});
        i_alrb_link_ctrl.frame({16'hc000, 1'b1, a, 32'h0});
        i_alrb_link_ctrl.frame(56'h0);
    endtask
    task automatic dsp(input logic we, input logic [5:0] i, input logic [15:0] d);
        @(posedge clk_in);
        dsp_req <= 1'b1;
        dsp_we <= we;
        dsp_idx <= i;
        dsp_wd <= d;
        @(posedge clk_in);
        dsp_req <= 1'b0;
        dchk <= !we;
        if (!we) dq.push_back(d);
        @(posedge clk_in);
        dchk <= 1'b0;
    endtask

    // Result watcher: oldest note against each result
    always @(posedge clk_in) begin
        if (rrq === 1'b1) rpc <= rpc + 1;
        if (dchk) chk("dsp read", dsp_rd, dq.pop_front());
        if (dchk) chk("dsp ready", rdy, 1'b1);
        if (rxd && rx[55] && rx[54])
            chk("link reply", {rx[53], rx[38:32], rx[19:4]}, lq.pop_front());
    end

    initial begin
        repeat (60000) @(posedge clk_in);
        num_errors++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        r0 = rnd();
        lw(7'h10, r0);
        lr(7'h10, r0);
        dsp(1'b0, 6'h08, r0);
        lw(7'h44, ~r0);
        lr(7'h44, ~r0);
        dsp(1'b1, 6'h14, 16'hffff);
        dsp(1'b1, 6'h1e, 16'hffff);
        lw(7'h28, 16'h0);
        lr(7'h28, 16'h7fff);
        lr(7'h3c, 16'h7fff);
        dsp(1'b0, 6'h14, 16'hffff);
        sel <= 1'b0;
        lr(7'h28, 16'h3fff);
        for (int k = 0; k < 2; k++) begin
            r = rnd();
            dsp(1'b1, 6'(62 + k), r);
            lw(7'(124 + 2 * k), ~r);
            lr(7'(124 + 2 * k), r);
            lw(7'(50 + 2 * k), r);
            lr(7'(50 + 2 * k), RATE_48K);
        end
        r = rnd();
        lw(7'h2a, r);
        lr(7'h2a, {r[15:10], 4'h7, r[5:0]});
        dsp(1'b1, 6'h13, 16'hffff);
        lr(7'h27, 16'h0);
        lw(7'h2c, RATE_44K);
        for (int k = 0; k < 3; k++) lr(7'(44 + 2 * k), RATE_44K);
        lw(7'h30, 16'hac45);
        for (int k = 0; k < 3; k++) lr(7'(44 + 2 * k), RATE_48K);
        lw(7'h2e, RATE_44K);
        lw(7'h5a, 16'h0);
        chk("compliance", fc, 1'b0);
        lr(7'h10, r0);
        lw(7'h00, rnd());
        chk("compliance", fc, 1'b1);
        chk("reset pulses", rpc, 1);
        lr(7'h2c, RATE_48K);
        r = rnd() | 16'h1000;
        lw(7'h26, r);
        chk("force low", bfl, 1'b1);
        i_alrb_link_ctrl.frame(56'h0);
        chk("data held low", rx, 56'h0);
        i_alrb_link_ctrl.warm();
        chk("force low", bfl, 1'b0);
        lr(7'h26, {r[15:13], 1'b0, r[11:4], 4'he});
        chk("pending", lq.size() + dq.size(), 0);
        chk("output enable", oe, 1'b1);
        final_report();
    end
endmodule
